// ---- src/bank_select_op_pkg.sv ----
// Function
// RL1 - A rotate left moves each bit up one place, the old top bit enters bit 0 and the carry.
// RL2 - A rotate right moves each bit down one place, the old bit 0 enters the top bit and the carry.
// RL3 - After a rotate the zero flag is set only when all eight result bits are zero.
// RL4 - There are thirty-two 8-bit registers in two banks, A and B, of sixteen each.
// RL5 - One bank is active; all operations but the alternate copy touch only the active bank.
// RL6 - Reset makes bank A active.
// RL7 - Bank select with operand A activates bank A, with operand B activates bank B.
// RL8 - One carry and one zero flag are shared, and bank select leaves both unchanged.
// RL9 - Switching banks never alters any stored register contents.
// RL10 - A bank switch completes within one instruction cycle of two clocks.
// RL11 - The alternate copy writes the active second operand into the inactive first operand.
// RL12 - The alternate copy leaves both flags unchanged.
// RL13 - An alternate copy with equal indices still writes the inactive register.
// RL14 - The bank is one state bit; the physical address is that bit (inverted for copy) and index.
package bank_select_op_pkg;

    localparam int NUM_BANKS     = 2;
    localparam int REGS_PER_BANK = 16;
    localparam int NUM_REGS      = NUM_BANKS * REGS_PER_BANK;
    localparam int DATA_W        = 8;
    localparam int IDX_W         = 4;
    localparam int PHYS_W        = 5;
    localparam int CYCLES_PER_INSTR = 2;

    localparam logic       BANK_A      = 1'b0;
    localparam logic       BANK_B      = 1'b1;
    localparam logic       BANK_RESET  = BANK_A;
    localparam logic [7:0] DATA_RESET  = 8'h00;
    localparam logic       FLAG_RESET  = 1'b0;

    // Operation codes from the decoder
    typedef enum logic [2:0] {
        OP_NONE                 = 3'b000,
        OP_LOAD                 = 3'b001,
        OP_ROTATE_LEFT          = 3'b010,
        OP_ROTATE_RIGHT         = 3'b011,
        OP_BANK_SELECT          = 3'b100,
        OP_ALTERNATE_BANK_COPY  = 3'b101
    } op_t;

    // Two-cycle instruction phase
    typedef enum logic [0:0] {
        PH_FETCH = 1'b0,
        PH_EXEC  = 1'b1
    } phase_t;

    // One instruction request
    typedef struct packed {
        op_t        op;
        logic [3:0] first_operand_reg;
        logic [3:0] second_operand_reg;
        logic       bank_operand;
        logic [7:0] load_data;
    } instr_t;

    // Flags
    typedef struct packed {
        logic carry;
        logic zero;
    } flags_t;

endpackage

// ---- src/rotate_unit.sv ----
`timescale 1ns/1ps
module rotate_unit
    import bank_select_op_pkg::*;
(
    input  wire logic [7:0] operand,   // Value before rotate
    input  wire logic       dir_left,  // High for left
    output logic [7:0]      result,    // Rotated value
    output logic            carry_out, // Bit moved around
    output logic            zero_out   // All result bits zero
);

    // Rotate datapath
    always_comb begin
        if (dir_left) begin
            result    = {operand[6:0], operand[7]}; // RL1
            carry_out = operand[7];                 // RL1
        end else begin
            result    = {operand[0], operand[7:1]}; // RL2
            carry_out = operand[0];                 // RL2
        end
        zero_out = (result == 8'h00);               // RL3
    end

endmodule // rotate_unit

// ---- src/bank_select_op_core.sv ----
`timescale 1ns/1ps
module bank_select_op_core
    import bank_select_op_pkg::*;
(
    input  wire logic   core_clk,    // System clock
    input  wire logic   rst,         // Sync reset, active high
    input  wire instr_t instr,       // Instruction from decoder
    input  wire logic   instr_valid, // Instruction offered
    output logic        instr_ready, // Instruction can be taken this cycle
    output logic [7:0]  first_data,  // Active first operand value
    output logic [7:0]  second_data, // Active second operand value
    output flags_t      flags,       // Carry and zero
    output logic        active_bank, // Current bank, 0 is A
    output logic        done         // Instruction completed
);

    // Storage and state
    logic [7:0]  regs_q [NUM_REGS]; // RL4
    logic [7:0]  regs_d [NUM_REGS];
    logic        bank_q, bank_d;
    flags_t      flags_q, flags_d;
    phase_t      phase_q, phase_d;
    instr_t      held_q, held_d;
    logic [7:0]  first_q, first_d;
    logic [7:0]  second_q, second_d;
    logic        done_q, done_d;

    logic [7:0]  rot_result;
    logic        rot_carry;
    logic        rot_zero;
    logic [4:0]  wr_addr;
    logic        wr_en;
    logic [7:0]  wr_data;

    // Physical address from bank bit and index
    function automatic logic [4:0] phys_addr(input logic bank, input logic [3:0] idx);
        phys_addr = {bank, idx}; // RL14
    endfunction

    rotate_unit u_rot (
        .operand   (regs_q[phys_addr(bank_q, held_q.first_operand_reg)]),
        .dir_left  (held_q.op == OP_ROTATE_LEFT),
        .result    (rot_result),
        .carry_out (rot_carry),
        .zero_out  (rot_zero)
    );

    assign instr_ready = (phase_q == PH_FETCH);

    // Write port selection
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = phys_addr(bank_q, held_q.first_operand_reg); // RL5
        wr_data = rot_result;
        if (phase_q == PH_EXEC) begin
            case (held_q.op)
                OP_LOAD: begin
                    wr_en   = 1'b1;
                    wr_data = held_q.load_data;
                end
                OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
                    wr_en = 1'b1;
                end
                OP_ALTERNATE_BANK_COPY: begin
                    // Destination in inactive bank, even for equal indices
                    wr_en   = 1'b1;                                         // RL13
                    wr_addr = phys_addr(~bank_q, held_q.first_operand_reg); // RL11
                    wr_data = regs_q[phys_addr(bank_q, held_q.second_operand_reg)]; // RL11
                end
                default: begin
                    wr_en = 1'b0;
                end
            endcase
        end
    end

    // Register array next state
    generate
        for (genvar i = 0; i < NUM_REGS; i++) begin : g_regs
            always_comb begin
                regs_d[i] = regs_q[i]; // RL9
                if (wr_en && (wr_addr == 5'(i))) begin
                    regs_d[i] = wr_data;
                end
            end
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    regs_q[i] <= DATA_RESET;
                end else begin
                    regs_q[i] <= regs_d[i];
                end
            end
        end
    endgenerate

    // Sequencing, bank and flags next state
    always_comb begin
        phase_d  = phase_q;
        held_d   = held_q;
        bank_d   = bank_q;
        flags_d  = flags_q;
        done_d   = 1'b0;
        first_d  = regs_q[phys_addr(bank_q, instr.first_operand_reg)];
        second_d = regs_q[phys_addr(bank_q, instr.second_operand_reg)];
        case (phase_q)
            PH_FETCH: begin
                if (instr_valid) begin
                    held_d  = instr;
                    phase_d = PH_EXEC;
                end
            end
            PH_EXEC: begin
                phase_d = PH_FETCH;
                done_d  = 1'b1; // RL10
                case (held_q.op)
                    OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
                        flags_d.carry = rot_carry; // RL1 RL2
                        flags_d.zero  = rot_zero;  // RL3
                    end
                    OP_BANK_SELECT: begin
                        bank_d = held_q.bank_operand; // RL7 RL8
                    end
                    default: begin
                        flags_d = flags_q; // RL12
                    end
                endcase
            end
            default: begin
                phase_d = PH_FETCH;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_q  <= PH_FETCH;
            held_q   <= '0;
            bank_q   <= BANK_RESET; // RL6
            flags_q  <= '{carry: FLAG_RESET, zero: FLAG_RESET};
            done_q   <= 1'b0;
            first_q  <= DATA_RESET;
            second_q <= DATA_RESET;
        end else begin
            phase_q  <= phase_d;
            held_q   <= held_d;
            bank_q   <= bank_d;
            flags_q  <= flags_d;
            done_q   <= done_d;
            first_q  <= first_d;
            second_q <= second_d;
        end
    end

    assign first_data  = first_q;
    assign second_data = second_q;
    assign flags       = flags_q;
    assign active_bank = bank_q;
    assign done        = done_q;

    // Check helpers, worked out from the rules and not from the datapath
    logic [4:0]  active_dest;
    logic [4:0]  alt_dest;
    logic [7:0]  exp_operand;
    logic [7:0]  exp_source;
    logic [7:0]  exp_left;
    logic [7:0]  exp_right;
    logic        exp_msb;
    logic        exp_lsb;
    logic        operand_zero;
    logic        offered_bank;
    logic        in_exec;
    logic        exec_rotate;
    logic        exec_select;
    logic        exec_copy;

    // Addresses and values an executing instruction should use
    assign active_dest  = {bank_q, held_q.first_operand_reg};
    assign alt_dest     = {~bank_q, held_q.first_operand_reg};
    assign exp_operand  = regs_q[active_dest];
    assign exp_source   = regs_q[{bank_q, held_q.second_operand_reg}];

    // Rotated values and the bit carried around
    assign exp_left     = {exp_operand[6:0], exp_operand[7]};
    assign exp_right    = {exp_operand[0], exp_operand[7:1]};
    assign exp_msb      = exp_operand[7];
    assign exp_lsb      = exp_operand[0];
    assign operand_zero = (exp_operand == 8'h00);

    // Phase and operation qualifiers
    assign in_exec      = (phase_q == PH_EXEC);
    assign exec_rotate  = in_exec && (held_q.op inside {OP_ROTATE_LEFT, OP_ROTATE_RIGHT});
    assign exec_select  = in_exec && (held_q.op == OP_BANK_SELECT);
    assign exec_copy    = in_exec && (held_q.op == OP_ALTERNATE_BANK_COPY);
    assign offered_bank = instr.bank_operand;

    // Rotate left result and carry
    AST_ROT_LEFT: assert property (@(posedge core_clk) disable iff (rst) // RL1
        (in_exec && held_q.op == OP_ROTATE_LEFT) |=>
        (regs_q[$past(active_dest)] == $past(exp_left)) &&
        (flags_q.carry == $past(exp_msb)))
        else $error("rotate left wrong");

    // Rotate right result and carry
    AST_ROT_RIGHT: assert property (@(posedge core_clk) disable iff (rst) // RL2
        (in_exec && held_q.op == OP_ROTATE_RIGHT) |=>
        (regs_q[$past(active_dest)] == $past(exp_right)) &&
        (flags_q.carry == $past(exp_lsb)))
        else $error("rotate right wrong");

    // Zero flag follows the rotated value
    AST_ROT_ZERO: assert property (@(posedge core_clk) disable iff (rst) // RL3
        exec_rotate |=> flags_q.zero == $past(operand_zero))
        else $error("rotate zero flag wrong");

    // Rotate writes back into the active register
    AST_ROT_WRITES: assert property (@(posedge core_clk) disable iff (rst) // RL5
        exec_rotate |-> wr_en && (wr_addr == active_dest))
        else $error("rotate written to wrong register");

    // Reset selects bank A
    AST_RESET_BANK: assert property (@(posedge core_clk) // RL6
        rst |=> bank_q == BANK_A)
        else $error("bank not A after reset");

    // Reset leaves the core ready and idle
    AST_RESET_READY: assert property (@(posedge core_clk) // RL6
        rst |=> instr_ready && !done)
        else $error("core not idle after reset");

    // Reset clears the shared flags
    AST_RESET_FLAGS: assert property (@(posedge core_clk) // RL8
        rst |=> (flags_q.carry == FLAG_RESET) && (flags_q.zero == FLAG_RESET))
        else $error("flags not cleared by reset");

    // Bank select takes effect within one instruction cycle
    AST_BANK_SEL: assert property (@(posedge core_clk) disable iff (rst) // RL7
        (instr_ready && instr_valid && instr.op == OP_BANK_SELECT) |=>
        ##1 bank_q == $past(offered_bank, 2))
        else $error("bank select wrong");

    // Bank moves only on an executed bank select
    AST_BANK_QUIET: assert property (@(posedge core_clk) disable iff (rst) // RL7
        !exec_select |=> $stable(bank_q))
        else $error("bank changed without select");

    // Bank select leaves the flags alone
    AST_BANK_FLAGS: assert property (@(posedge core_clk) disable iff (rst) // RL8
        exec_select |=> $stable(flags_q))
        else $error("bank select changed flags");

    // Flags move only on a rotate
    AST_FLAGS_QUIET: assert property (@(posedge core_clk) disable iff (rst) // RL12
        !exec_rotate |=> $stable(flags_q))
        else $error("flags changed without rotate");

    // A bank switch writes no register
    AST_SWITCH_KEEPS: assert property (@(posedge core_clk) disable iff (rst) // RL9
        exec_select |-> !wr_en)
        else $error("bank switch wrote a register");

    // Copy leaves the flags alone
    AST_COPY_FLAGS: assert property (@(posedge core_clk) disable iff (rst) // RL12
        exec_copy |=> $stable(flags_q))
        else $error("copy changed flags");

    // Copy targets the inactive bank
    AST_COPY_DEST: assert property (@(posedge core_clk) disable iff (rst) // RL11
        exec_copy |-> wr_en && (wr_addr == alt_dest))
        else $error("copy not to inactive bank");

    // Copy carries the active source value
    AST_COPY_DATA: assert property (@(posedge core_clk) disable iff (rst) // RL11
        exec_copy |=> regs_q[$past(alt_dest)] == $past(exp_source))
        else $error("copy data wrong");

    // Equal indices still overwrite the inactive register
    AST_COPY_SAME: assert property (@(posedge core_clk) disable iff (rst) // RL13
        (exec_copy && (held_q.first_operand_reg == held_q.second_operand_reg)) |=>
        regs_q[$past(alt_dest)] == $past(exp_operand))
        else $error("same index copy lost");

    // Load lands at the bank bit and index
    AST_LOAD_WRITE: assert property (@(posedge core_clk) disable iff (rst) // RL14
        (in_exec && held_q.op == OP_LOAD) |->
        wr_en && (wr_addr == active_dest) && (wr_data == held_q.load_data))
        else $error("load written wrong");

    // Other writes stay in the active bank
    AST_ACTIVE_ONLY: assert property (@(posedge core_clk) disable iff (rst) // RL5
        (wr_en && !exec_copy) |-> wr_addr == active_dest)
        else $error("write outside active bank");

    // An empty operation writes nothing
    AST_NONE_QUIET: assert property (@(posedge core_clk) disable iff (rst) // RL5
        (in_exec && held_q.op == OP_NONE) |-> !wr_en)
        else $error("empty operation wrote a register");

    // Whole instruction in two clocks
    AST_TWO_CYCLES: assert property (@(posedge core_clk) disable iff (rst) // RL10
        (instr_ready && instr_valid) |=> !instr_ready ##1 (instr_ready && done))
        else $error("instruction not two cycles");

    // Completion pulse lasts one clock
    AST_DONE_PULSE: assert property (@(posedge core_clk) disable iff (rst) // RL10
        done |=> !done)
        else $error("done longer than one clock");

endmodule // bank_select_op_core

// ---- verification/sequencer_model.sv ----
`timescale 1ns/1ps
module sequencer_model
    import bank_select_op_pkg::*;
(
    input  wire logic       core_clk,    // System clock
    input  wire logic       instr_ready, // Core in fetch phase
    input  wire logic       done,        // Core finished
    input  wire logic [7:0] first_data,  // Active first operand
    input  wire logic [7:0] second_data, // Active second operand
    output instr_t          instr,       // Instruction offered
    output logic            instr_valid  // Offer qualifier
);
    // Idle bus, valid low
    initial begin
        instr       = instr_t'(20'h5_A5A5);
        instr_valid = 1'b0;
    end

    // Offer until taken, then count cycles to done
    task automatic issue(input instr_t i, output int cyc);
        int n;
        cyc = 99;
        @(negedge core_clk);
        instr       = i;
        instr_valid = 1'b1;
        for (n = 0; n < 8 && instr_ready !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        if (instr_ready === 1'b1) begin
            @(negedge core_clk);
            instr_valid = 1'b0;
            instr       = ~i; // Released bus shows no stale value
            for (n = 1; n < 8 && done !== 1'b1; n++) begin
                @(negedge core_clk);
            end
            if (done === 1'b1) cyc = n;
        end
    endtask

    // Look at one active register on both operand outputs with nothing offered
    task automatic peek(input logic [3:0] a, output logic [7:0] va, output logic [7:0] vb);
        instr_t q;
        q                    = '0;
        q.first_operand_reg  = a;
        q.second_operand_reg = a;
        @(negedge core_clk);
        instr = q;
        repeat (2) @(negedge core_clk);
        va    = first_data;
        vb    = second_data;
        instr = ~q;
    endtask
endmodule // sequencer_model

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end
module testbench;
    import bank_select_op_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst      = 1'b1;
    instr_t     instr;
    logic       instr_valid;
    logic       instr_ready;
    logic       active_bank;
    logic       done;
    logic [7:0] first_data;
    logic [7:0] second_data;
    flags_t     flags;
    int         err_count    = 0;
    int         total_checks = 0;

    // 20 MHz clock
    always #25 core_clk = ~core_clk;

    bank_select_op_core dut (.core_clk(core_clk), .rst(rst), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .first_data(first_data),
        .second_data(second_data), .flags(flags), .active_bank(active_bank), .done(done));
    sequencer_model u_seq (.core_clk(core_clk), .instr_ready(instr_ready), .done(done),
        .first_data(first_data), .second_data(second_data), .instr(instr),
        .instr_valid(instr_valid));

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // One instruction, completion two clocks after it is taken
    task automatic run(input op_t op, input logic [3:0] a, input logic [3:0] b,
                       input logic bk, input logic [7:0] d);
        instr_t i;
        int     cyc;
        i = '{op, a, b, bk, d};
        u_seq.issue(i, cyc);
        `CHK("cycles to done", CYCLES_PER_INSTR, cyc)
        if (cyc > 8) conclude();
    endtask

    // Both operand outputs must show the register
    task automatic chk_reg(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] va;
        logic [7:0] vb;
        u_seq.peek(a, va, vb);
        `CHK("first operand", exp, va)
        `CHK("second operand", exp, vb)
    endtask

    task automatic do_reset;
        @(negedge core_clk);
        rst = 1'b1;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        `CHK("bank after reset", BANK_A, active_bank)
        `CHK("flags after reset", {FLAG_RESET, FLAG_RESET}, flags)
        $display("reset test done");
    endtask

    task automatic t_rotate;
        op_t        ops [4] = '{OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT};
        logic [7:0] vin [4] = '{8'h81, 8'h81, 8'h00, 8'h7E};
        logic [7:0] vout[4] = '{8'h03, 8'hC0, 8'h00, 8'h3F};
        logic [1:0] fl  [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
        for (int k = 0; k < 4; k++) begin
            run(OP_LOAD, 4'h3, 4'h0, 1'b0, vin[k]);
            run(ops[k], 4'h3, 4'h0, 1'b0, 8'h00);
            chk_reg(4'h3, vout[k]);
            `CHK("rotate flags", fl[k], flags)
        end
        $display("rotate test done");
    endtask

    task automatic t_banks;
        run(OP_LOAD, 4'hF, 4'h0, 1'b0, 8'h11);
        run(OP_ROTATE_LEFT, 4'h1, 4'h0, 1'b0, 8'h00);
        run(OP_BANK_SELECT, 4'h0, 4'h0, BANK_B, 8'h00);
        `CHK("bank", BANK_B, active_bank)
        `CHK("flags kept", 2'h1, flags)
        chk_reg(4'hF, 8'h00);
        run(OP_LOAD, 4'hF, 4'h0, 1'b0, 8'h22);
        run(OP_BANK_SELECT, 4'h0, 4'h0, BANK_A, 8'h00);
        `CHK("bank", BANK_A, active_bank)
        chk_reg(4'hF, 8'h11);
        $display("bank test done");
    endtask

    task automatic t_copy;
        run(OP_LOAD, 4'h7, 4'h0, 1'b0, 8'h5A);
        run(OP_ROTATE_RIGHT, 4'h3, 4'h0, 1'b0, 8'h00);
        run(OP_ALTERNATE_BANK_COPY, 4'h7, 4'h7, 1'b0, 8'h00);
        run(OP_ALTERNATE_BANK_COPY, 4'h2, 4'h7, 1'b0, 8'h00);
        `CHK("flags kept", 2'h2, flags)
        run(OP_NONE, 4'h2, 4'h7, BANK_B, 8'hFF);
        `CHK("flags after none", 2'h2, flags)
        `CHK("bank after none", BANK_A, active_bank)
        chk_reg(4'h2, 8'h00);
        run(OP_BANK_SELECT, 4'h0, 4'h0, BANK_B, 8'h00);
        chk_reg(4'h7, 8'h5A);
        chk_reg(4'h2, 8'h5A);
        chk_reg(4'hF, 8'h22);
        $display("copy test done");
    endtask

    // Main sequence, ending with a reset while bank B is active
    initial begin
        do_reset();
        t_rotate();
        t_banks();
        t_copy();
        do_reset();
        conclude();
    end
endmodule // testbench
